/* File: rtl/pwr_wake_ctl.sv */
// Power state sequencer, wake event logic and clock gating controls
`timescale 1ns/1ps
// Functional notes
// - Latch per-port wake status on PHY interrupt
// - Masked port statuses ORed set wake interrupt
// - Enabled wake interrupt ORed into irq
// - Wake interrupt status sets regardless of enable
// - Auto wake exits D1 and D2
// - Fabric clock disable needs two one-writes
// - PTP unit disable needs two one-writes
// - Timestamp unit disables need two one-writes
// - Clock gating freezes blocks, no reset
// - LED disable releases or deasserts LEDs
// - Power states keep all configuration but mode and sleep
// - Any reset enters D0
// - D1 stops system clocks, keeps PLL, crystal
// - D2 drops PLL when both PHYs down
// - D3 stops crystal, PLL, system and network clocks, manual exit only
// - System clocks only D0, crystal D0-D2
// - Mode and sleep change together ignored
// - Low-power entry forces ready low
// - Host writes ignored while asleep; power control still reads in full
// - Mode codes 000-011 are D0-D3
// - Wake completion sets ready, clears mode, sleep
module pwr_wake_ctl #(
    parameter int NLED = 2,
    parameter logic [NLED-1:0] LED_OD = '0,
    parameter logic [NLED-1:0] LED_ACT_HI = '1
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state
    input wire logic [pwr_wake_pkg::ADDR_W-1:0] awaddr, // AXI write addr
    input wire logic awvalid, // AXI
    output logic awready, // AXI
    input wire logic [31:0] wdata, // AXI write data
    input wire logic [3:0] wstrb, // AXI byte strobes
    input wire logic wvalid, // AXI
    output logic wready, // AXI
    output logic [1:0] bresp, // AXI write response
    output logic bvalid, // AXI
    input wire logic bready, // AXI
    input wire logic [pwr_wake_pkg::ADDR_W-1:0] araddr, // AXI read addr
    input wire logic arvalid, // AXI
    output logic arready, // AXI
    output logic [31:0] rdata, // AXI read data
    output logic [1:0] rresp, // AXI read response
    output logic rvalid, // AXI
    input wire logic rready, // AXI
    input wire logic phy_a_int, // Port A PHY interrupt pin
    input wire logic phy_b_int, // Port B PHY interrupt pin
    input wire logic phy_a_pdown, // Port A PHY in power-down
    input wire logic phy_b_pdown, // Port B PHY in power-down
    input wire logic manual_wake, // Host bus activity wake pin
    input wire logic pll_locked, // PLL lock pin
    input wire logic other_int, // Other interrupt sources
    input wire logic [NLED-1:0] led_req, // LED on requests
    output logic irq, // Interrupt request, active high
    output logic sys_clk_en, // System clock enable
    output logic pll_en, // PLL enable
    output logic pll_off_req, // PLL shutdown request
    output logic xtal_en, // Crystal oscillator enable
    output logic net_clk_en, // External network clock gate
    output logic host_if_ready, // Host interfaces functional
    output logic fabric_clk_en, // Switch fabric clock enable
    output logic ptp_clk_en, // PTP unit clock enable
    output logic [pwr_wake_pkg::TSU_N-1:0] tsu_clk_en, // Timestamp units
    output logic [NLED-1:0] led_o, // LED level
    output logic [NLED-1:0] led_oe // LED drive enable
);
    import pwr_wake_pkg::*;

    typedef struct packed {
        logic [2:0] mode;
        logic sleep;
        logic autow;
        logic led_outputs_disable;
        logic ptp_dis;
        logic ptp_p;
        logic fab_dis;
        logic fab_p;
        logic [TSU_N-1:0] tsu_dis;
        logic [TSU_N-1:0] tsu_p;
        logic [1:0] wsts;
        logic [1:0] wen;
        logic pint;
        logic pint_en;
        logic ready;
        pwr_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [SY_N-1:0] sy1;
        logic [SY_N-1:0] sy2;
        logic awf;
        logic wf;
        logic awrdy;
        logic wrdy;
        logic arrdy;
        logic bvalid;
        logic rvalid;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] rdata;
        logic sys_en;
        logic pll_en;
        logic pll_off;
        logic xtal_en;
        logic net_en;
        logic host_rdy;
        logic fab_en;
        logic ptp_en;
        logic [TSU_N-1:0] tsu_en;
        logic irq;
        logic [NLED-1:0] led_o;
        logic [NLED-1:0] led_oe;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0] off);
        hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    function automatic logic [31:0] wmask(input logic [3:0] st);
        wmask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    endfunction

    // Returns {bit, pending}; set needs two consecutive one-writes
    function automatic logic [1:0] dbl(input logic cur, input logic pend,
                                       input logic we, input logic wv);
        if (!we) begin
            dbl = {cur, pend};
        end else if (!wv) begin
            dbl = 2'b00;
        end else if (cur || pend) begin
            dbl = 2'b10;
        end else begin
            dbl = 2'b01;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [31:0] m;
        logic [31:0] r;
        logic [1:0] t;
        logic wake;
        m = wmask(s_q.wstrb);
        r = '0;
        t = '0;
        wake = 1'b0;
        s_d = s_q;
        s_d.sy1 = {pll_locked, manual_wake, phy_b_pdown, phy_a_pdown,
                   phy_b_int, phy_a_int};
        s_d.sy2 = s_q.sy1;

        // Bus channel capture
        if (s_q.awrdy && awvalid) begin
            s_d.awf = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (s_q.wrdy && wvalid) begin
            s_d.wf = 1'b1;
            s_d.wdata = wdata;
            s_d.wstrb = wstrb;
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end

        // Register writes; ignored while the device is not ready
        if (s_q.awf && s_q.wf && !s_q.bvalid) begin
            s_d.awf = 1'b0;
            s_d.wf = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (!s_q.ready) begin
                s_d.bresp = RESP_OKAY;
            end else if (hit(s_q.awaddr, OFF_PWR_CTL)) begin
                if (m[SLEEP_BIT] && s_q.wdata[SLEEP_BIT] && m[MODE_LSB]
                    && s_q.wdata[MODE_LSB +: 3] != s_q.mode) begin
                    s_d.mode = s_q.mode;
                end else begin
                    if (m[MODE_LSB]) begin
                        s_d.mode = s_q.wdata[MODE_LSB +: 3];
                    end
                    if (m[SLEEP_BIT]) begin
                        s_d.sleep = s_q.wdata[SLEEP_BIT];
                    end
                end
                if (m[AUTOW_BIT]) begin
                    s_d.autow = s_q.wdata[AUTOW_BIT];
                end
                if (m[LED_BIT]) begin
                    s_d.led_outputs_disable = s_q.wdata[LED_BIT];
                end
                t = dbl(s_q.fab_dis, s_q.fab_p, m[FAB_BIT],
                        s_q.wdata[FAB_BIT]);
                {s_d.fab_dis, s_d.fab_p} = t;
                t = dbl(s_q.ptp_dis, s_q.ptp_p, m[PTP_BIT],
                        s_q.wdata[PTP_BIT]);
                {s_d.ptp_dis, s_d.ptp_p} = t;
                for (int i = 0; i < TSU_N; i++) begin
                    t = dbl(s_q.tsu_dis[i], s_q.tsu_p[i], m[TSU_LSB + i],
                            s_q.wdata[TSU_LSB + i]);
                    {s_d.tsu_dis[i], s_d.tsu_p[i]} = t;
                end
                for (int i = 0; i < 2; i++) begin
                    if (m[WEN_LSB + i]) begin
                        s_d.wen[i] = s_q.wdata[WEN_LSB + i];
                    end
                    if (m[WSTS_LSB + i] && s_q.wdata[WSTS_LSB + i]) begin
                        s_d.wsts[i] = 1'b0;
                    end
                end
            end else if (hit(s_q.awaddr, OFF_INTERRUPT_STATUS_REG)) begin
                if (m[PINT_BIT] && s_q.wdata[PINT_BIT]) begin
                    s_d.pint = 1'b0;
                end
            end else if (hit(s_q.awaddr, OFF_INT_EN)) begin
                if (m[PINT_EN_BIT]) begin
                    s_d.pint_en = s_q.wdata[PINT_EN_BIT];
                end
            end else if (!hit(s_q.awaddr, OFF_HARDWARE_CONFIG_REG)) begin
                s_d.bresp = RESP_SLVERR;
            end
        end

        // Register reads; power control and ready read in full while asleep, status and enable read as zero
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_q.arrdy && arvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            if (hit(araddr, OFF_PWR_CTL)) begin
                r[MODE_LSB +: 3] = s_q.mode;
                r[SLEEP_BIT] = s_q.sleep;
                r[AUTOW_BIT] = s_q.autow;
                r[LED_BIT] = s_q.led_outputs_disable;
                r[PTP_BIT] = s_q.ptp_dis;
                r[TSU_LSB +: TSU_N] = s_q.tsu_dis;
                r[FAB_BIT] = s_q.fab_dis;
                r[WEN_LSB +: 2] = s_q.wen;
                r[WSTS_LSB +: 2] = s_q.wsts;
                r[RDY_BIT] = s_q.ready;
            end else if (hit(araddr, OFF_HARDWARE_CONFIG_REG)) begin
                r[HWCFG_RDY_BIT] = s_q.ready;
            end else if (hit(araddr, OFF_INTERRUPT_STATUS_REG)) begin
                r[PINT_BIT] = s_q.pint && s_q.ready;
            end else if (hit(araddr, OFF_INT_EN)) begin
                r[PINT_EN_BIT] = s_q.pint_en && s_q.ready;
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
            s_d.rdata = r;
        end
        s_d.awrdy = !s_d.awf;
        s_d.wrdy = !s_d.wf;
        s_d.arrdy = !s_d.rvalid;

        // Wake events; hardware set wins over a clearing write
        if (s_q.sy2[SY_INTA]) begin
            s_d.wsts[0] = 1'b1;
        end
        if (s_q.sy2[SY_INTB]) begin
            s_d.wsts[1] = 1'b1;
        end
        if (|(s_q.wsts & s_q.wen)) begin
            s_d.pint = 1'b1;
        end
        wake = s_q.autow && s_q.pint;

        // Power state sequencer
        case (s_q.st)
            ST_D0: begin
                if (s_q.sleep && s_q.ready) begin
                    s_d.ready = 1'b0;
                    s_d.cnt = CNT_W'(SETTLE_CYC);
                    case (s_q.mode)
                        MODE_D1: s_d.st = ST_D1;
                        MODE_D2: s_d.st = ST_D2;
                        MODE_D3: s_d.st = ST_D3;
                        default: s_d.st = ST_WAKE;
                    endcase
                end
            end
            ST_D1, ST_D2: begin
                if (s_q.sy2[SY_MAN] || wake) begin
                    s_d.st = ST_WAKE;
                end
            end
            ST_D3: begin
                if (s_q.sy2[SY_MAN]) begin
                    s_d.st = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - CNT_W'(1);
                end else if (s_q.sy2[SY_LOCK]) begin
                    s_d.st = ST_D0;
                    s_d.ready = 1'b1;
                    s_d.mode = MODE_D0;
                    s_d.sleep = 1'b0;
                end
            end
            default: begin
                s_d.st = ST_D0;
            end
        endcase
        // Only mode, sleep, ready and the settle counter change with the state; all else is kept

        // Registered outputs
        s_d.sys_en = (s_d.st == ST_D0);
        s_d.xtal_en = (s_d.st != ST_D3);
        s_d.net_en = (s_d.st != ST_D3);
        s_d.pll_off = (s_d.st == ST_D2) || (s_d.st == ST_D3);
        s_d.pll_en = (s_d.st == ST_D0) || (s_d.st == ST_D1)
            || (s_d.st == ST_WAKE) || ((s_d.st == ST_D2)
            && !(s_q.sy2[SY_PDA] && s_q.sy2[SY_PDB]));
        s_d.host_rdy = s_d.ready;
        // Gated blocks hold their state; nothing here resets them
        s_d.fab_en = !s_d.fab_dis;
        s_d.ptp_en = !s_d.ptp_dis;
        s_d.tsu_en = ~s_d.tsu_dis;
        s_d.irq = (s_d.pint && s_d.pint_en) || other_int;
        for (int i = 0; i < NLED; i++) begin
            if (LED_OD[i]) begin
                s_d.led_o[i] = LED_ACT_HI[i];
                s_d.led_oe[i] = led_req[i] && !s_d.led_outputs_disable;
            end else begin
                s_d.led_o[i] = (led_req[i] && !s_d.led_outputs_disable)
                    ? LED_ACT_HI[i] : !LED_ACT_HI[i];
                s_d.led_oe[i] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset always lands in D0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.st <= ST_D0;
            s_q.ready <= 1'b1;
            s_q.awrdy <= 1'b1;
            s_q.wrdy <= 1'b1;
            s_q.arrdy <= 1'b1;
            s_q.sys_en <= 1'b1;
            s_q.pll_en <= 1'b1;
            s_q.xtal_en <= 1'b1;
            s_q.net_en <= 1'b1;
            s_q.host_rdy <= 1'b1;
            s_q.fab_en <= 1'b1;
            s_q.ptp_en <= 1'b1;
            s_q.tsu_en <= '1;
            s_q.led_o <= ~LED_ACT_HI;
            s_q.led_oe <= ~LED_OD;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign awready = s_q.awrdy;
    assign wready = s_q.wrdy;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arrdy;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;
    assign irq = s_q.irq;
    assign sys_clk_en = s_q.sys_en;
    assign pll_en = s_q.pll_en;
    assign pll_off_req = s_q.pll_off;
    assign xtal_en = s_q.xtal_en;
    assign net_clk_en = s_q.net_en;
    assign host_if_ready = s_q.host_rdy;
    assign fabric_clk_en = s_q.fab_en;
    assign ptp_clk_en = s_q.ptp_en;
    assign tsu_clk_en = s_q.tsu_en;
    assign led_o = s_q.led_o;
    assign led_oe = s_q.led_oe;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_port_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && s_q.sy2[SY_INTA] |=> s_q.wsts[0])
        else $error("port A wake status not latched");
    chk_wake_int_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ce && |(s_q.wsts & s_q.wen) |=> s_q.pint)
        else $error("wake interrupt status not set");
    chk_irq_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && aresetn |=> irq == ((s_q.pint && s_q.pint_en)
        || $past(other_int)))
        else $error("irq not raised for wake interrupt");
    chk_fab_double: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(s_q.fab_dis) |-> $past(s_q.fab_p))
        else $error("fabric disable set on single write");
    chk_ptp_double: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(s_q.ptp_dis) |-> $past(s_q.ptp_p))
        else $error("ptp disable set on single write");
    chk_sleep_ready: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_q.st != ST_D0 |-> !s_q.ready && !host_if_ready)
        else $error("ready high outside D0");
    chk_d1_clocks: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.st == ST_D1 |-> pll_en && xtal_en && !sys_clk_en)
        else $error("D1 clock controls wrong");
    chk_d3_clocks: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.st == ST_D3 |-> !xtal_en && !pll_en && !net_clk_en)
        else $error("D3 clock controls wrong");
    chk_d3_manual: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.st == ST_D3 && !s_q.sy2[SY_MAN] |=> s_q.st == ST_D3)
        else $error("D3 left without manual wake");
    chk_wake_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(s_q.ready) |-> s_q.mode == MODE_D0 && !s_q.sleep)
        else $error("mode or sleep not cleared on wake");
    chk_reset_d0: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> s_q.st == ST_D0 && sys_clk_en)
        else $error("reset did not enter D0");
endmodule

/* File: pkg/pwr_wake_pkg.sv */
// Constants for the power management and wake control block
package pwr_wake_pkg;
    localparam int ADDR_W = 12;
    localparam int TSU_N = 3;
    // Register byte offsets
    localparam logic [11:0] OFF_INTERRUPT_STATUS_REG = 12'h058;
    localparam logic [11:0] OFF_INT_EN = 12'h05c;
    localparam logic [11:0] OFF_HARDWARE_CONFIG_REG = 12'h074;
    localparam logic [11:0] OFF_PWR_CTL = 12'h084;
    // power_control_reg fields
    localparam int MODE_LSB = 29;
    localparam int SLEEP_BIT = 28;
    localparam int AUTOW_BIT = 27;
    localparam int LED_BIT = 26;
    localparam int PTP_BIT = 25;
    localparam int TSU_LSB = 22;
    localparam int FAB_BIT = 21;
    localparam int WEN_LSB = 6;
    localparam int WSTS_LSB = 4;
    localparam int RDY_BIT = 0;
    // interrupt_status_reg, interrupt enable and hardware_config_reg
    localparam int PINT_BIT = 17;
    localparam int PINT_EN_BIT = 17;
    localparam int HWCFG_RDY_BIT = 27;
    // Power mode codes; 100 to 111 are reserved
    localparam logic [2:0] MODE_D0 = 3'h0;
    localparam logic [2:0] MODE_D1 = 3'h1;
    localparam logic [2:0] MODE_D2 = 3'h2;
    localparam logic [2:0] MODE_D3 = 3'h3;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Pin synchroniser lanes
    localparam int SY_N = 6;
    localparam int SY_INTA = 0;
    localparam int SY_INTB = 1;
    localparam int SY_PDA = 2;
    localparam int SY_PDB = 3;
    localparam int SY_MAN = 4;
    localparam int SY_LOCK = 5;
    // Least PLL settle time on wake-up
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    typedef enum logic [4:0] {
        ST_D0 = 5'h01,
        ST_D1 = 5'h02,
        ST_D2 = 5'h04,
        ST_D3 = 5'h08,
        ST_WAKE = 5'h10
    } pwr_state_t;
endpackage

/* File: bench/pwr_wake_ctl_tb.sv */
// Self-checking bench for the power management and wake control block
`timescale 1ns/1ps
module pwr_wake_ctl_tb;
import pwr_wake_pkg::*;
logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
logic [ADDR_W-1:0] awaddr, araddr;
logic [31:0] wdata, rdata, rd_v, m;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, rs;
logic awready, wready, bvalid, arready, rvalid;
logic phy_a_int, phy_b_int, phy_a_pdown, phy_b_pdown, manual_wake;
logic pll_locked, other_int, irq, sys_clk_en, pll_en, pll_off_req;
logic xtal_en, net_clk_en, host_if_ready, fabric_clk_en, ptp_clk_en;
logic [TSU_N-1:0] tsu_clk_en;
logic [1:0] led_req, led_o, led_oe;
int bad_count = 0;
int checks = 0;
localparam logic [15:0] PM = 16'h003f;
localparam logic [15:0] CM = 16'h07c0;
localparam logic [15:0] LM = 16'h7800;
localparam logic [15:0] IM = 16'h8000;
localparam logic [31:0] RDY = 32'h1;
localparam logic [31:0] AW = 32'h1 << AUTOW_BIT;
localparam logic [31:0] WA = 32'h1 << WEN_LSB;
localparam logic [31:0] SA = 32'h1 << WSTS_LSB;
localparam logic [31:0] SL = 32'h1 << SLEEP_BIT;
localparam logic [31:0] PI = 32'h1 << PINT_BIT;
localparam logic [31:0] M1 = 32'(MODE_D1) << MODE_LSB;
localparam logic [31:0] M2 = 32'(MODE_D2) << MODE_LSB;
localparam logic [31:0] M3 = 32'(MODE_D3) << MODE_LSB;

pwr_wake_ctl #(.LED_OD(2'b10)) u_pwr_wake_ctl (.aclk, .aresetn, .ce,
    .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .phy_a_int, .phy_b_int, .phy_a_pdown, .phy_b_pdown, .manual_wake,
    .pll_locked, .other_int, .led_req, .irq, .sys_clk_en, .pll_en,
    .pll_off_req, .xtal_en, .net_clk_en, .host_if_ready, .fabric_clk_en,
    .ptp_clk_en, .tsu_clk_en, .led_o, .led_oe);

////////////////////////////////////////////////////////////////////////////
initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
end

task complete_run;
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask

task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
        bad_count++;
        $display("ERROR %0t: value %h expected %h", $time, g, e);
    end
endtask

task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    checks++;
    if (g !== e) begin
        bad_count++;
        $display("ERROR %0t: response %h expected %h", $time, g, e);
    end
endtask

// Output pins packed: irq, led_o, led_oe, clock enables, power pins
function automatic logic [15:0] outs();
    return {irq, led_o, led_oe, ptp_clk_en, tsu_clk_en, fabric_clk_en,
        sys_clk_en, pll_en, pll_off_req, xtal_en, net_clk_en, host_if_ready};
endfunction

task automatic chk(input logic [15:0] msk, input logic [15:0] e);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    cmp({16'h0, outs() & msk}, {16'h0, e});
    @(posedge aclk);
endtask

////////////////////////////////////////////////////////////////////////////
// Values seen at the falling edge are what the next rising edge samples
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
        @(negedge aclk);
        ta = awvalid && awready;
        tw = wvalid && wready;
        tb = bvalid;
        rs = bresp;
        @(posedge aclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        if (tb) break;
    end
    if (n == 50) begin
        bad_count++;
        complete_run();
    end
endtask

task automatic rd(input logic [11:0] a);
    logic ta, tr;
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
        @(negedge aclk);
        ta = arvalid && arready;
        tr = rvalid;
        rd_v = rdata;
        rs = rresp;
        @(posedge aclk);
        if (ta) arvalid <= 1'b0;
        if (tr) break;
    end
    if (n == 50) begin
        bad_count++;
        complete_run();
    end
endtask

task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    cmp(rd_v, e);
    cmp_resp(rs, RESP_OKAY);
endtask

task automatic wup;
    int n;
    for (n = 0; n < 2000; n++) begin
        @(negedge aclk);
        if (host_if_ready === 1'b1) break;
    end
    @(posedge aclk);
    if (n == 2000) begin
        bad_count++;
        complete_run();
    end
endtask

task automatic rst;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
endtask

task automatic slp(input logic [31:0] cfg);
    wr(OFF_PWR_CTL, cfg);
    wr(OFF_PWR_CTL, cfg | SL);
    repeat (6) @(posedge aclk);
endtask

////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (100000) @(posedge aclk);
    bad_count++;
    complete_run();
end

initial begin
    {aresetn, ce, awvalid, wvalid, arvalid} = 5'b01000;
    {bready, rready, pll_locked, other_int, manual_wake} = 5'b11100;
    {phy_a_int, phy_b_int, phy_a_pdown, phy_b_pdown} = 4'h0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    led_req = 2'b00;
    rst();
    chk(PM | CM | LM | IM, 16'h4ff7);
    rdc(OFF_PWR_CTL, RDY);
    rdc(OFF_HARDWARE_CONFIG_REG, 32'h1 << HWCFG_RDY_BIT);
    rd(12'h100);
    cmp_resp(rs, RESP_SLVERR);
    wr(12'h100, 32'h0);
    cmp_resp(rs, RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
        m = 32'h1 << (FAB_BIT + i);
        wr(OFF_PWR_CTL, m);
        chk(CM, 16'h07c0);
        wr(OFF_PWR_CTL, m);
        chk(CM, 16'h07c0 ^ (16'h0040 << i));
        rdc(OFF_PWR_CTL, m | RDY);
        wr(OFF_PWR_CTL, 32'h0);
        wr(OFF_PWR_CTL, m);
        wr(OFF_PWR_CTL, 32'h0);
        wr(OFF_PWR_CTL, m);
        chk(CM, 16'h07c0);
        wr(OFF_PWR_CTL, 32'h0);
    end
    led_req <= 2'b11;
    chk(LM, 16'h7800);
    wr(OFF_PWR_CTL, 32'h1 << LED_BIT);
    chk(LM, 16'h4800);
    wr(OFF_PWR_CTL, 32'h0);
    led_req <= 2'b00;
    phy_a_int <= 1'b1;
    repeat (8) @(posedge aclk);
    phy_a_int <= 1'b0;
    rdc(OFF_PWR_CTL, SA | RDY);
    rdc(OFF_INTERRUPT_STATUS_REG, 32'h0);
    wr(OFF_PWR_CTL, WA);
    rdc(OFF_INTERRUPT_STATUS_REG, PI);
    chk(IM, 16'h0);
    wr(OFF_INT_EN, 32'h1 << PINT_EN_BIT);
    chk(IM, 16'h8000);
    wr(OFF_PWR_CTL, WA | SA);
    rdc(OFF_PWR_CTL, WA | RDY);
    wr(OFF_INTERRUPT_STATUS_REG, PI);
    chk(IM, 16'h0);
    other_int <= 1'b1;
    chk(IM, 16'h8000);
    other_int <= 1'b0;
    wr(OFF_PWR_CTL, M2 | SL);
    rdc(OFF_PWR_CTL, RDY);
    chk(PM, 16'h0037);
    slp(32'h8000_0000);
    wup();
    rdc(OFF_PWR_CTL, RDY);
    slp(M1 | AW | WA);
    chk(PM, 16'h0016);
    rdc(OFF_PWR_CTL, M1 | AW | WA | SL);
    rdc(OFF_HARDWARE_CONFIG_REG, 32'h0);
    rdc(OFF_INTERRUPT_STATUS_REG, 32'h0);
    wr(OFF_PWR_CTL, 32'h0);
    rdc(OFF_PWR_CTL, M1 | AW | WA | SL);
    phy_a_int <= 1'b1;
    wup();
    phy_a_int <= 1'b0;
    rdc(OFF_PWR_CTL, AW | WA | SA | RDY);
    wr(OFF_PWR_CTL, SA);
    wr(OFF_INTERRUPT_STATUS_REG, PI);
    phy_a_pdown <= 1'b1;
    phy_b_pdown <= 1'b1;
    slp(M3 | AW | WA);
    chk(PM, 16'h0008);
    phy_a_int <= 1'b1;
    repeat (200) @(posedge aclk);
    chk(PM, 16'h0008);
    rdc(OFF_INTERRUPT_STATUS_REG, 32'h0);
    manual_wake <= 1'b1;
    wup();
    manual_wake <= 1'b0;
    phy_a_int <= 1'b0;
    chk(PM, 16'h0037);
    wr(OFF_PWR_CTL, SA);
    wr(OFF_INTERRUPT_STATUS_REG, PI);
    phy_a_pdown <= 1'b1;
    phy_b_pdown <= 1'b1;
    slp(M2);
    chk(PM, 16'h000e);
    phy_b_pdown <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(PM, 16'h001e);
    rst();
    chk(PM | CM, 16'h07f7);
    rdc(OFF_PWR_CTL, RDY);
    complete_run();
end
endmodule
